/* File: pkg/plm_pkg.sv */
// constants, field layout and mode codes of the port low-nibble mode block
package plm_pkg;

    // =====================================================================
    // register map: printed offsets are indices, byte address is index * 4
    localparam logic [7:0]  PLM_IDX_IRQ_EN   = 8'he5;
    localparam logic [7:0]  PLM_IDX_LOW_MODE = 8'hed;
    localparam logic [7:0]  PLM_IDX_PULLUP   = 8'hee;
    localparam logic [31:0] PLM_ADDR_IRQ_EN   = {22'h000000, PLM_IDX_IRQ_EN, 2'h0};
    localparam logic [31:0] PLM_ADDR_LOW_MODE = {22'h000000, PLM_IDX_LOW_MODE, 2'h0};

    // =====================================================================
    // reset values
    localparam logic [7:0] PLM_RST_IRQ_EN   = 8'h00;
    localparam logic [7:0] PLM_RST_LOW_MODE = 8'h00;

    // =====================================================================
    // field layout: pin n mode at bits 2n+1:2n
    localparam int PLM_MODE_W    = 2;
    localparam int PLM_LOW_PINS  = 4;
    localparam int PLM_PORT_PINS = 8;

    // =====================================================================
    // pin mode codes
    localparam logic [1:0] PLM_MODE_IN_FALL = 2'h0;
    localparam logic [1:0] PLM_MODE_IN_BOTH = 2'h1;
    localparam logic [1:0] PLM_MODE_OUT_PP  = 2'h2;
    localparam logic [1:0] PLM_MODE_IN_RISE = 2'h3;

    // =====================================================================
    // ahb-lite codes
    localparam logic [1:0] PLM_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PLM_HSIZE_WORD    = 3'h2;

    // does an edge (previous -> current level) count as an event in this mode
    function automatic logic plm_edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        unique case (mode)
            PLM_MODE_IN_FALL: plm_edge_hit = fall;
            PLM_MODE_IN_BOTH: plm_edge_hit = rise | fall;
            PLM_MODE_IN_RISE: plm_edge_hit = rise;
            PLM_MODE_OUT_PP:  plm_edge_hit = 1'b0;
        endcase
    endfunction : plm_edge_hit

endpackage : plm_pkg

/* File: core/plm_edge_detect.sv */
// synchroniser and mode-selected edge detector for the port pins
`timescale 1ns/1ps
module plm_edge_detect #(
    parameter int PINS = 8
) (
    input  wire logic                  ref_clk,   // cpu clock
    input  wire logic                  resetn,    // sync reset, active low
    input  wire logic [PINS-1:0]       pinIn,     // raw pin levels
    input  wire logic [2*PINS-1:0]     pinMode,   // 2-bit mode per pin
    output logic      [PINS-1:0]       edgeHit    // one-cycle edge event per pin
);
    import plm_pkg::*;

    typedef struct packed {
        logic [PINS-1:0] meta;
        logic [PINS-1:0] sync;
        logic [PINS-1:0] prev;
        logic [2:0]      warm;
    } plm_ed_state_t;

    plm_ed_state_t st;
    plm_ed_state_t next_st;

    // =====================================================================
    // state update
    always_comb begin
        next_st      = st;
        next_st.meta = pinIn;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
        // stages come out of reset at zero; hold off the first compare so a pin
        // already high at release does not look like a rise
        next_st.warm = {st.warm[1:0], 1'b1};
        if (!resetn) begin
            next_st = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // =====================================================================
    // detection reads only the second and third stages
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            edgeHit[i] = resetn & st.warm[2] & plm_edge_hit(pinMode[2*i +: 2], st.prev[i], st.sync[i]);
        end
    end

endmodule : plm_edge_detect

/* File: core/plm_port_ctrl.sv */
// port low-nibble mode control and port interrupt enable, ahb-lite slave
`timescale 1ns/1ps
module plm_port_ctrl #(
    parameter int PINS = plm_pkg::PLM_PORT_PINS
) (
    input  wire logic              ref_clk,          // cpu clock, 50 mhz
    input  wire logic              resetn,           // sync reset, active low
    // ahb-lite slave
    input  wire logic              hsel,             // slave select
    input  wire logic [31:0]       haddr,            // byte address
    input  wire logic [1:0]        htrans,           // transfer type
    input  wire logic              hwrite,           // write when high
    input  wire logic [2:0]        hsize,            // transfer size
    input  wire logic [31:0]       hwdata,           // write data
    input  wire logic              hready,           // bus ready
    output logic                   hreadyout,        // slave ready
    output logic                   hresp,            // always okay
    output logic [31:0]            hrdata,           // read data
    // pins
    input  wire logic [PINS-1:0]   portPinIn,        // pin levels, asynchronous
    input  wire logic [3:0]        portDataOut,      // output data for low pins
    output logic [3:0]             portPinOut,       // low pin output value
    output logic [3:0]             portPinOe,        // low pin drive enable
    output logic [3:0]             portPullupOn,     // low pin pull-up control
    // neighbours
    input  wire logic [7:0]        portHighPinMode,  // upper-nibble mode register
    input  wire logic [PINS-1:0]   portPullupEnable, // pull-up register contents
    input  wire logic [PINS-1:0]   portIrqPending,   // pending flag register contents
    output logic [PINS-1:0]        portEdgeEvent,    // one-cycle pulse, sets pending flag
    output logic [7:0]             portIrqEnable,    // enable register contents
    output logic [7:0]             portLowPinMode,   // low mode register contents
    output logic                   extIrqSourceFive, // pin 0 request
    output logic                   extIrqSourceSix,  // pin 1 request
    output logic                   extIrqSourceSeven,// pin 2 request
    output logic                   extIrqSourceEight,// pin 3 request
    output logic                   extIrqSourceNine  // pins 4 to 7 request
);
    import plm_pkg::*;

    typedef enum logic [1:0] {
        PLM_SEL_NONE,
        PLM_SEL_IRQ_EN,
        PLM_SEL_LOW_MODE
    } plm_sel_t;

    typedef struct packed {
        logic [7:0]      irqEn;
        logic [7:0]      lowMode;
        logic            wrPend;
        plm_sel_t        wrSel;
        logic [31:0]     rdata;
        logic            ready;
        logic            resp;
        logic [PINS-1:0] event_q;
        logic [4:0]      irq;
        logic [3:0]      oe;
        logic [3:0]      dout;
        logic [3:0]      pull;
    } plm_state_t;

    plm_state_t st;
    plm_state_t next_st;

    logic [PINS-1:0]   edgeHit;
    logic [2*PINS-1:0] allMode;

    // =====================================================================
    // helpers
    function automatic plm_sel_t plm_decode(input logic [31:0] addr);
        if (addr == PLM_ADDR_IRQ_EN) begin
            plm_decode = PLM_SEL_IRQ_EN;
        end else if (addr == PLM_ADDR_LOW_MODE) begin
            plm_decode = PLM_SEL_LOW_MODE;
        end else begin
            plm_decode = PLM_SEL_NONE;
        end
    endfunction : plm_decode

    // read mux; unmapped offsets read as zero
    function automatic logic [7:0] plm_read_mux(input plm_sel_t sel, input logic [7:0] irqEn,
                                                input logic [7:0] lowMode);
        unique case (sel)
            PLM_SEL_IRQ_EN:   plm_read_mux = irqEn;
            PLM_SEL_LOW_MODE: plm_read_mux = lowMode;
            PLM_SEL_NONE:     plm_read_mux = 8'h00;
            default:          plm_read_mux = 8'h00;
        endcase
    endfunction : plm_read_mux

    // drive enables of the low pins, one per 2-bit mode field
    function automatic logic [3:0] plm_oe_mask(input logic [7:0] mode);
        logic [3:0] oe;
        oe = 4'h0;
        for (int i = 0; i < PLM_LOW_PINS; i++) begin
            oe[i] = (mode[2*i +: PLM_MODE_W] == PLM_MODE_OUT_PP);
        end
        plm_oe_mask = oe;
    endfunction : plm_oe_mask

    // pins 0 to 3 own a source each, pins 4 to 7 share the fifth
    function automatic logic [4:0] plm_irq_route(input logic [7:0] req);
        logic [4:0] src;
        src    = 5'h00;
        src[0] = req[0];
        src[1] = req[1];
        src[2] = req[2];
        src[3] = req[3];
        src[4] = |req[7:4];
        plm_irq_route = src;
    endfunction : plm_irq_route

    // =====================================================================
    // edge detection, upper modes come from the neighbouring register
    // upper pins are sensed here too, so source nine sees pins 4 to 7 of the port
    assign allMode = {portHighPinMode, st.lowMode};

    plm_edge_detect #(
        .PINS (PINS)
    ) u_edge (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pinIn   (portPinIn),
        .pinMode (allMode),
        .edgeHit (edgeHit)
    );

    // =====================================================================
    // next state
    always_comb begin
        plm_sel_t   sel;
        logic [7:0] rd8;
        logic       take;
        logic [PINS-1:0] req;
        sel     = PLM_SEL_NONE;
        rd8     = 8'h00;
        take    = 1'b0;
        req     = '0;
        next_st = st;

        // data phase of a previous write lands first, so a read taken in the
        // same cycle already sees the new value
        if (st.wrPend) begin
            unique case (st.wrSel)
                PLM_SEL_IRQ_EN:   next_st.irqEn   = hwdata[7:0];
                PLM_SEL_LOW_MODE: next_st.lowMode = hwdata[7:0];
                PLM_SEL_NONE:     next_st.irqEn   = st.irqEn;
                default:          next_st.irqEn   = st.irqEn;
            endcase
        end

        // zero-wait slave: a selected NONSEQ address phase is taken whenever the bus is ready
        take           = hsel & hready & (htrans == PLM_HTRANS_NONSEQ);
        sel            = plm_decode(haddr);
        next_st.wrPend = take & hwrite & (hsize == PLM_HSIZE_WORD);
        next_st.wrSel  = sel;
        next_st.ready  = 1'b1;
        // nothing is refused with an error; unmapped offsets just read zero
        next_st.resp   = 1'b0;

        // read data forwarded from a write still in its data phase
        rd8 = plm_read_mux(sel, next_st.irqEn, next_st.lowMode);
        if (take && !hwrite) begin
            next_st.rdata = {24'h000000, rd8};
        end

        // pulse to the pending register, which holds set-over-clear priority
        next_st.event_q = edgeHit;

        // request only while pending and enabled, pin by pin; the flags live
        // outside, so a clear shows on the sources one cycle after it lands
        req         = portIrqPending & st.irqEn;
        next_st.irq = plm_irq_route(req);

        // pins; drive enable trails the mode register by one cycle
        next_st.oe   = plm_oe_mask(st.lowMode);
        next_st.dout = portDataOut;
        // output pins do not use the pull-up
        next_st.pull = portPullupEnable[3:0] & ~next_st.oe;

        if (!resetn) begin
            next_st         = '0;
            next_st.irqEn   = PLM_RST_IRQ_EN;
            next_st.lowMode = PLM_RST_LOW_MODE;
            next_st.wrSel   = PLM_SEL_NONE;
            // bus stays ready in reset so a master never hangs on it
            next_st.ready   = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // =====================================================================
    // outputs, all straight from state
    // hresp is registered too, though only okay is ever answered
    assign hreadyout         = st.ready;
    assign hresp             = st.resp;
    assign hrdata            = st.rdata;
    assign portPinOut        = st.dout;
    assign portPinOe         = st.oe;
    assign portPullupOn      = st.pull;
    assign portEdgeEvent     = st.event_q;
    assign portIrqEnable     = st.irqEn;
    assign portLowPinMode    = st.lowMode;
    assign extIrqSourceFive  = st.irq[0];
    assign extIrqSourceSix   = st.irq[1];
    assign extIrqSourceSeven = st.irq[2];
    assign extIrqSourceEight = st.irq[3];
    assign extIrqSourceNine  = st.irq[4];

endmodule : plm_port_ctrl

/* File: testbench/plm_port_ctrl_chk.sv */
// bound assertions on the port controller ports
`timescale 1ns/1ps
module plm_port_ctrl_chk #(
    parameter int PINS = 8
) (
    input wire logic            ref_clk, resetn,                  // clock, reset
    input wire logic            hsel, hwrite, hready, hreadyout, hresp, // bus control
    input wire logic [31:0]     haddr, hwdata, hrdata,            // bus data
    input wire logic [1:0]      htrans,                           // transfer type
    input wire logic [2:0]      hsize,                            // transfer size
    input wire logic [PINS-1:0] portPinIn, portIrqPending, portEdgeEvent, // pins, flags
    input wire logic [3:0]      portPinOe,                        // drive enable
    input wire logic [7:0]      portIrqEnable, portLowPinMode,    // registers
    input wire logic            extIrqSourceFive, extIrqSourceNine // requests
);
    import plm_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // =========
    // helpers
    wire logic take = hsel && hready && htrans == PLM_HTRANS_NONSEQ;
    wire logic [1:0] m0 = portLowPinMode[1:0];
    wire logic [3:0] oeExp = {portLowPinMode[7:6] == 2'h2, portLowPinMode[5:4] == 2'h2,
                              portLowPinMode[3:2] == 2'h2, m0 == 2'h2};
    sequence s_wr_en;
        take && hwrite && hsize == PLM_HSIZE_WORD && haddr == PLM_ADDR_IRQ_EN ##1 1'b1;
    endsequence
    // =========
    // bus and pins
    chk_okay_ready: assert property (hreadyout && !hresp) else $error("bus stall");
    chk_read_mode: assert property (take && !hwrite && haddr == PLM_ADDR_LOW_MODE |=>
        hrdata == {24'h000000, portLowPinMode}) else $error("mode read");
    chk_write_en: assert property (s_wr_en |=> portIrqEnable == $past(hwdata[7:0])) else $error("en write");
    chk_oe_mode: assert property ($stable(portLowPinMode) |-> portPinOe == oeExp) else $error("oe");
    chk_fall_event: assert property ($fell(portPinIn[0]) && m0 == PLM_MODE_IN_FALL |->
        ##[2:5] portEdgeEvent[0]) else $error("fall event");
    chk_rise_none: assert property ($rose(portPinIn[0]) && m0 == PLM_MODE_IN_FALL |->
        ##1 !portEdgeEvent[0] [*5]) else $error("rise in fall mode");
    chk_both_event: assert property ($changed(portPinIn[0]) && m0 == PLM_MODE_IN_BOTH |->
        ##[2:5] portEdgeEvent[0]) else $error("both event");
    chk_rise_event: assert property ($rose(portPinIn[0]) && m0 == PLM_MODE_IN_RISE |->
        ##[2:5] portEdgeEvent[0]) else $error("rise event");
    chk_out_quiet: assert property ((m0 == PLM_MODE_OUT_PP) [*5] |-> !portEdgeEvent[0]) else $error("out event");
    chk_irq_five: assert property (extIrqSourceFive == $past(portIrqPending[0] && portIrqEnable[0]))
        else $error("source five");
    chk_irq_nine: assert property (extIrqSourceNine == $past(|(portIrqPending[7:4] & portIrqEnable[7:4])))
        else $error("source nine");
endmodule : plm_port_ctrl_chk

bind plm_port_ctrl plm_port_ctrl_chk #(.PINS(PINS)) u_chk (.ref_clk, .resetn, .hsel, .hwrite, .hready,
    .hreadyout, .hresp, .haddr, .hwdata, .hrdata, .htrans, .hsize, .portPinIn, .portIrqPending,
    .portEdgeEvent, .portPinOe, .portIrqEnable, .portLowPinMode, .extIrqSourceFive, .extIrqSourceNine);

/* File: testbench/plm_board_model.sv */
// board side of the port: pin levels and pending flags
`timescale 1ns/1ps
module plm_board_model (
    input  wire logic       ref_clk,        // cpu clock
    input  wire logic       resetn,         // sync reset, active low
    input  wire logic [7:0] boardLevel,     // level the board drives
    input  wire logic [3:0] portPinOut,     // low pin output value
    input  wire logic [3:0] portPinOe,      // low pin drive enable
    input  wire logic [7:0] portEdgeEvent,  // edge pulses
    input  wire logic       clrStb,         // pending write strobe
    input  wire logic [7:0] clrData,        // pending write data
    output logic      [7:0] portPinIn,      // resolved pin levels
    output logic      [7:0] portIrqPending  // pending flags
);
    always_comb begin
        portPinIn = boardLevel;
        for (int i = 0; i < 4; i++) begin
            if (portPinOe[i]) portPinIn[i] = portPinOut[i];
        end
    end
    // a set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) portIrqPending <= 8'h00;
        else portIrqPending <= (portIrqPending & (clrStb ? clrData : 8'hff)) | portEdgeEvent;
    end
endmodule : plm_board_model

/* File: testbench/plm_port_ctrl_test.sv */
// self-checking bench for the port low-nibble controller
`timescale 1ns/1ps
module plm_port_ctrl_test;
    import plm_pkg::*;
    logic ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0, clrStb = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rdv;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic [3:0]  portDataOut = 0, portPinOut, portPinOe, portPullupOn;
    logic [7:0]  boardLevel = 0, portHighPinMode = 0, portPullupEnable = 0, clrData = 0;
    logic [7:0]  portPinIn, portIrqPending, portEdgeEvent, portIrqEnable, portLowPinMode, md, pend, en;
    logic [15:0] mall;
    logic        extIrqSourceFive, extIrqSourceSix, extIrqSourceSeven, extIrqSourceEight, extIrqSourceNine;
    logic [3:0]  oeMdl;
    wire logic [4:0] irqSeen = {extIrqSourceNine, extIrqSourceEight, extIrqSourceSeven, extIrqSourceSix,
                                extIrqSourceFive};
    int nErrors = 0, checkCount = 0, evCnt[8], mdl[int], m, mi;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) for (int i = 0; i < 8; i++) evCnt[i] += (portEdgeEvent[i] === 1'b1);
    plm_port_ctrl u_dut (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .portPinIn, .portDataOut, .portPinOut, .portPinOe,
        .portPullupOn, .portHighPinMode, .portPullupEnable, .portIrqPending, .portEdgeEvent, .portIrqEnable,
        .portLowPinMode, .extIrqSourceFive, .extIrqSourceSix, .extIrqSourceSeven, .extIrqSourceEight,
        .extIrqSourceNine);
    plm_board_model u_brd (.ref_clk, .resetn, .boardLevel, .portPinOut, .portPinOe, .portEdgeEvent,
        .clrStb, .clrData, .portPinIn, .portIrqPending);
    // =========
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d checks %0d", nErrors, checkCount);
        if (nErrors == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task automatic wt();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            nErrors++;
            results();
        end
    endtask : wt
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= PLM_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= a;
        hsize <= PLM_HSIZE_WORD;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        rdv = hrdata;
        if (w && mdl.exists(a)) mdl[a] = d[7:0];
    endtask : bus
    task automatic rd(input logic [31:0] a);
        bus(1'b0, a, 32'h0);
        chk(rdv, mdl.exists(a) ? mdl[a] : 0);
    endtask : rd
    // =========
    // sequence
    initial begin
        mdl[PLM_ADDR_IRQ_EN] = 0;
        mdl[PLM_ADDR_LOW_MODE] = 0;
        m = $urandom(32'he604);
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(PLM_ADDR_IRQ_EN);
        rd(PLM_ADDR_LOW_MODE);
        bus(1'b1, 32'h3b8, 32'hff);
        rd(32'h3b8);
        repeat (4) begin
            bus(1'b1, PLM_ADDR_IRQ_EN, $urandom);
            bus(1'b1, PLM_ADDR_LOW_MODE, $urandom);
            rd(PLM_ADDR_IRQ_EN);
            rd(PLM_ADDR_LOW_MODE);
        end
        // upper pins held high in rise mode across a reset must not report a rise
        boardLevel <= 8'hf0;
        portHighPinMode <= 8'hff;
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        evCnt = '{default: 0};
        mdl[PLM_ADDR_IRQ_EN] = 0;
        mdl[PLM_ADDR_LOW_MODE] = 0;
        rd(PLM_ADDR_IRQ_EN);
        rd(PLM_ADDR_LOW_MODE);
        repeat (6) @(posedge ref_clk);
        chk(evCnt[4] + evCnt[5] + evCnt[6] + evCnt[7], 0);
        boardLevel <= 8'h00;
        repeat (6) @(posedge ref_clk);
        for (m = 0; m < 4; m++) begin
            for (int i = 0; i < 4; i++) md[2*i+:2] = 2'((m + i) % 4);
            bus(1'b1, PLM_ADDR_LOW_MODE, {24'h0, md});
            portHighPinMode <= md ^ 8'h55;
            portPullupEnable <= 8'($urandom);
            clrData <= 8'h00;
            clrStb <= 1'b1;
            repeat (6) @(posedge ref_clk);
            clrStb <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                oeMdl[i] = md[2*i+:2] == PLM_MODE_OUT_PP;
                chk(portPinOe[i], oeMdl[i]);
            end
            chk(portPullupOn, portPullupEnable[3:0] & ~oeMdl);
            evCnt = '{default: 0};
            boardLevel <= 8'hff;
            repeat (8) @(posedge ref_clk);
            boardLevel <= 8'h00;
            repeat (8) @(posedge ref_clk);
            mall = {portHighPinMode, md};
            for (int i = 0; i < 8; i++) begin
                mi = mall[2*i+:2];
                chk(evCnt[i], mi == 1 ? 2 : (mi == 2 ? 0 : 1));
                pend[i] = mi != 2;
            end
            en = 8'($urandom);
            bus(1'b1, PLM_ADDR_IRQ_EN, {24'h0, en});
            repeat (2) begin
                repeat (3) @(posedge ref_clk);
                chk(portIrqPending, pend);
                chk(irqSeen, {|(pend[7:4] & en[7:4]), pend[3:0] & en[3:0]});
                clrData <= 8'($urandom);
                clrStb <= 1'b1;
                @(posedge ref_clk);
                clrStb <= 1'b0;
                pend &= clrData;
            end
        end
        portDataOut <= 4'($urandom);
        repeat (2) @(posedge ref_clk);
        chk(portPinOut, portDataOut);
        results();
    end
endmodule : plm_port_ctrl_test
